/* rtl/spp_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH
`define SPP_OFF_MARK 4'h0
`define SPP_OFF_SIZE 4'h4
`define SPP_OFF_IDLE 4'h8
`define SPP_OFF_STAT 4'hc
`define SPP_MARK1_LSB 0
`define SPP_MARK2_LSB 8
`define SPP_PROC_LSB 16
`define SPP_STAT_DRAIN_BIT 16
`define SPP_RST_MARK 8'h00
`define SPP_RST_PROC 2'h0
`define SPP_RST_SIZE 11'h000
`define SPP_RST_IDLE 16'h0000
`define SPP_BUF_BYTES 11'h400
`define SPP_CLK_PS 10000
`define SPP_TICK_PS 1000000000
`define SPP_TICK_CYC (`SPP_TICK_PS / `SPP_CLK_PS)
`endif

/* rtl/spp_pkg.sv */
// Types shared by the serial packet packer
package spp_pkg;
  typedef enum logic [0:0] {
    SPP_ST_FILL = 1'b0,
    SPP_ST_DRAIN = 1'b1
  } spp_state_t;
  typedef enum logic [1:0] {
    SPP_PR_PLAIN = 2'b00,
    SPP_PR_PLUS1 = 2'b01,
    SPP_PR_PLUS2 = 2'b10,
    SPP_PR_STRIP = 2'b11
  } spp_proc_t;
  typedef struct packed {
    logic [7:0] mark1;
    logic [7:0] mark2;
    spp_proc_t proc;
    logic [10:0] size_lim;
    logic [15:0] idle_ms;
  } spp_cfg_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } spp_beat_t;
endpackage

/* rtl/spp_packer.sv */
// Serial byte packer: 1 KB buffer released as network frames
//
// Our own choices: the register offsets and register access over Avalon-MM.
`include "spp_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module spp_packer
  import spp_pkg::*;
#(
  parameter int unsigned TICK_CYC = `SPP_TICK_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // A zero marker setting never matches, so disabled markers stay inert
  function automatic logic is_mark(input logic [7:0] b, input logic [7:0] m);
    return (m != 8'h00) && (b == m);
  endfunction

  spp_cfg_t cfg_q, cfg_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] w_mark, w_size, w_idle, w_stat;

  spp_state_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [10:0] len_q, len_d;
  logic [10:0] rdp_q, rdp_d;
  logic d1s_q, d1s_d;
  logic [1:0] trl_q, trl_d;
  logic [15:0] tmr_q, tmr_d;
  logic [31:0] div_q, div_d;
  spp_beat_t out_q, out_d;
  logic rdy_q, rdy_d;
  logic [7:0] mem [0:1023];
  logic wr_en, flush, take, mk_on, two, mk_hit;
  logic [10:0] mlen;

  // Register images
  always_comb begin
    w_mark = 32'h0;
    w_mark[`SPP_MARK1_LSB +: 8] = cfg_q.mark1;
    w_mark[`SPP_MARK2_LSB +: 8] = cfg_q.mark2;
    w_mark[`SPP_PROC_LSB +: 2] = cfg_q.proc;
    w_size = {21'h0, cfg_q.size_lim};
    w_idle = {16'h0, cfg_q.idle_ms};
    w_stat = {15'h0, st_q == SPP_ST_DRAIN, 5'h0, cnt_q};
  end

  // Avalon slave: one wait cycle, then the access completes
  // Core never stalls the bus, so the answer time is fixed
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    cfg_d = cfg_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      unique case (avs_address)
        `SPP_OFF_MARK: rdata_d = w_mark;
        `SPP_OFF_SIZE: rdata_d = w_size;
        `SPP_OFF_IDLE: rdata_d = w_idle;
        `SPP_OFF_STAT: rdata_d = w_stat;
        default: rdata_d = 32'h0;
      endcase
    end
    // Write lands on the completion edge, not the take edge
    if (avs_write && !wait_q) begin
      unique case (avs_address)
        `SPP_OFF_MARK: begin
          m = merge(w_mark, avs_writedata, avs_byteenable);
          cfg_d.mark1 = m[`SPP_MARK1_LSB +: 8];
          cfg_d.mark2 = m[`SPP_MARK2_LSB +: 8];
          cfg_d.proc = spp_proc_t'(m[`SPP_PROC_LSB +: 2]);
        end
        `SPP_OFF_SIZE: begin
          m = merge(w_size, avs_writedata, avs_byteenable);
          cfg_d.size_lim = m[10:0];
        end
        `SPP_OFF_IDLE: begin
          m = merge(w_idle, avs_writedata, avs_byteenable);
          cfg_d.idle_ms = m[15:0];
        end
        default: m = 32'h0;
      endcase
    end
  end

  // Config changes apply at once, even mid-frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '{mark1: `SPP_RST_MARK, mark2: `SPP_RST_MARK, proc: SPP_PR_PLAIN,
                 size_lim: `SPP_RST_SIZE, idle_ms: `SPP_RST_IDLE};
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Marker decode; a lone second marker counts as no marker
  always_comb begin
    // Only the first marker turns marker mode on
    mk_on = cfg_q.mark1 != 8'h00;
    two = cfg_q.mark2 != 8'h00;
    mlen = two ? 11'd2 : 11'd1;
    if (two) begin
      mk_hit = d1s_q && is_mark(rx_data, cfg_q.mark2);
    end else begin
      mk_hit = is_mark(rx_data, cfg_q.mark1);
    end
    take = rx_valid && rdy_q && st_q == SPP_ST_FILL;
  end

  // Packer sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    len_d = len_q;
    rdp_d = rdp_q;
    d1s_d = d1s_q;
    trl_d = trl_q;
    tmr_d = tmr_q;
    div_d = div_q;
    out_d = out_q;
    wr_en = 1'b0;
    flush = 1'b0;
    unique case (st_q)
      SPP_ST_FILL: begin
        if (take) begin
          wr_en = 1'b1;
          cnt_d = 11'(cnt_q + 11'd1);
          tmr_d = 16'h0;
          div_d = 32'h0;
          if (!mk_on) begin
            flush = 1'b1;
          end else if (trl_q != 2'd0) begin
            // Markers inside trailing bytes are plain data
            trl_d = 2'(trl_q - 2'd1);
            flush = trl_q == 2'd1;
            d1s_d = 1'b0;
          end else if (mk_hit) begin
            d1s_d = 1'b0;
            unique case (cfg_q.proc)
              SPP_PR_PLAIN: flush = 1'b1;
              SPP_PR_PLUS1: trl_d = 2'd1;
              SPP_PR_PLUS2: trl_d = 2'd2;
              SPP_PR_STRIP: begin
                wr_en = 1'b0;
                // First byte of a two-byte marker is already stored
                cnt_d = 11'(cnt_q + 11'd1 - mlen);
                flush = 1'b1;
              end
            endcase
          end else begin
            d1s_d = two && is_mark(rx_data, cfg_q.mark1);
          end
          // Checked on the next count, so a stripped marker frees room
          if (cnt_d == `SPP_BUF_BYTES) begin
            flush = 1'b1;
          end
          if (cfg_q.size_lim != 11'h0 && cnt_d >= cfg_q.size_lim) begin
            flush = 1'b1;
          end
        end else if (cnt_q != 11'h0 && cfg_q.idle_ms != 16'h0) begin
          // Divider restarts on each byte so the wait is exact to a cycle
          if (div_q == 32'(TICK_CYC - 1)) begin
            div_d = 32'h0;
            tmr_d = 16'(tmr_q + 16'd1);
            flush = tmr_d >= cfg_q.idle_ms;
          end else begin
            div_d = 32'(div_q + 32'd1);
          end
        end
        // Strip may leave nothing to send
        if (flush && cnt_d != 11'h0) begin
          st_d = SPP_ST_DRAIN;
          len_d = cnt_d;
          rdp_d = 11'h0;
          trl_d = 2'd0;
          d1s_d = 1'b0;
          tmr_d = 16'h0;
          div_d = 32'h0;
        end
      end
      SPP_ST_DRAIN: begin
        // Count clears only once the last beat is accepted
        if (out_q.valid && tx_ready && out_q.last) begin
          out_d.valid = 1'b0;
          st_d = SPP_ST_FILL;
          cnt_d = 11'h0;
        end else if (!out_q.valid || tx_ready) begin
          if (rdp_q < len_q) begin
            out_d.valid = 1'b1;
            out_d.data = mem[rdp_q[9:0]];
            out_d.last = rdp_q == 11'(len_q - 11'd1);
            rdp_d = 11'(rdp_q + 11'd1);
          end else begin
            out_d.valid = 1'b0;
          end
        end
      end
    endcase
  end

  // Ready from a flop, so the serial side sees no combinational path
  always_comb begin
    rdy_d = st_d == SPP_ST_FILL;
  end

  // Buffer storage; no reset needed on the array
  // Read side is asynchronous; a block RAM would need a read stage
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[cnt_q[9:0]] <= rx_data;
    end
  end

  // Sequencer flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= SPP_ST_FILL;
      cnt_q <= 11'h0;
      len_q <= 11'h0;
      rdp_q <= 11'h0;
      d1s_q <= 1'b0;
      trl_q <= 2'd0;
      tmr_q <= 16'h0;
      div_q <= 32'h0;
      out_q <= '{valid: 1'b0, data: 8'h00, last: 1'b0};
      rdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      rdp_q <= rdp_d;
      d1s_q <= d1s_d;
      trl_q <= trl_d;
      tmr_q <= tmr_d;
      div_q <= div_d;
      out_q <= out_d;
      rdy_q <= rdy_d;
    end
  end

  // Every output is a flop
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rx_ready = rdy_q;
  assign tx_valid = out_q.valid;
  assign tx_data = out_q.data;
  assign tx_last = out_q.last;

endmodule
`default_nettype wire

/* testbench/spp_packer_checker.sv */
// Port assertions for the serial packet packer
`timescale 1ns/10ps
`default_nettype none
module spp_packer_checker #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [19:0] gap_q;
  logic [19:0] gap_d;
  wire take = rx_valid && rx_ready;
  // Saturates so a long idle spell never wraps
  always_comb gap_d = take ? 20'h0 : gap_q + {19'h0, ~&gap_q};
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      gap_q <= 20'h0;
    else
      gap_q <= gap_d;
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rel;
    take ##1 !rx_ready;
  endsequence
  sequence s_end;
    tx_valid && tx_ready && tx_last;
  endsequence
  bus_answer_a:
    assert property (s_req |-> ##[1:2] !avs_waitrequest) else $error("bus not answered");
  wait_pulse_a:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
  beat_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("beat changed while stalled");
  no_overlap_a:
    assert property (tx_valid |-> !rx_ready) else $error("input open during frame");
  frame_end_a:
    assert property (s_end |=> !tx_valid && rx_ready) else $error("no resume after frame");
  release_lat_a:
    assert property (s_rel |=> tx_valid) else $error("frame late after release");
  idle_wait_a:
    assert property ($fell(rx_ready) && !$past(take) |-> gap_q >= TICK_CYC)
    else $error("idle release too early");
  reset_out_a:
    assert property ($rose(arst_n) |-> !rx_ready && !tx_valid && avs_waitrequest ##1 rx_ready)
    else $error("bad state after reset");
endmodule
bind spp_packer spp_packer_checker #(.TICK_CYC(TICK_CYC)) i_spp_packer_checker (
  .clock(clock), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire

/* testbench/spp_far_model.sv */
// Frame sink on the network side of the packer
`timescale 1ns/10ps
`default_nettype none
module spp_far_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic slow,
  output logic tx_ready,
  output logic [15:0] frames,
  output logic [10:0] flen,
  output logic [7:0] lastb
);
  logic [10:0] cnt_q;
  // Slow mode drops ready every other cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
      cnt_q <= 11'h0;
      frames <= 16'h0;
      flen <= 11'h0;
      lastb <= 8'h0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        cnt_q <= tx_last ? 11'h0 : cnt_q + 11'h1;
        if (tx_last) begin
          frames <= frames + 16'h1;
          flen <= cnt_q + 11'h1;
          lastb <= tx_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_spp_packer.sv */
// Self-checking bench for the serial packet packer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_spp_packer;
  logic clock = 0, arst_n = 0, avs_read = 0, avs_write = 0, rx_valid = 0, slow = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data = 8'h0, tx_data, lastb;
  logic [15:0] frames, nfr = 16'h0;
  logic [10:0] flen;
  int mismatches = 0, num_checks = 0;
  spp_packer #(.TICK_CYC(10)) i_spp_packer (.clock(clock), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  spp_far_model i_spp_far_model (.clock(clock), .arst_n(arst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready),
    .frames(frames), .flen(flen), .lastb(lastb));
  initial forever #5 clock = ~clock;
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tmo(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    tmo(n, 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Bytes go every second cycle, far below the idle gap
  task send(input logic [7:0] b);
    int n;
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= b;
    for (n = 0; n < 5000; n++) begin
      @(posedge clock);
      if (rx_ready === 1'b1) break;
    end
    tmo(n, 5000);
    rx_valid <= 1'b0;
  endtask
  task frame(input logic [15:0] k);
    int n;
    nfr = nfr + k;
    for (n = 0; n < 5000 && frames !== nfr; n++) @(negedge clock);
    tmo(n, 5000);
  endtask
  task cfg(input logic [31:0] m, input logic [31:0] s, input logic [31:0] i);
    bus(1'b1, 4'h0, m);
    bus(1'b1, 4'h4, s);
    bus(1'b1, 4'h8, i);
  endtask
  task t_regs;
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, k == 4 ? 4'h2 : 4'(k * 4), 32'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    `CHK(rd, 32'h0)
    cfg(32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(rd, 32'h0003_ffff)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(rd, 32'h0000_07ff)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rd, 32'h0000_ffff)
    cfg(32'h0, 32'h0, 32'h0);
  endtask
  task t_nomark;
    send(8'h41);
    send(8'h42);
    frame(16'h2);
    `CHK(flen, 11'h1)
    `CHK(lastb, 8'h42)
    cfg(32'h3a00, 32'h0, 32'h0);
    send(8'h41);
    send(8'h3a);
    frame(16'h2);
    `CHK(flen, 11'h1)
    `CHK(lastb, 8'h3a)
  endtask
  task t_opts;
    for (int p = 0; p < 4; p++) begin
      cfg({14'h0, 2'(p), 16'h000d}, 32'h0, 32'h0);
      send(8'h41);
      send(8'h0d);
      for (int j = 0; j < p && p < 3; j++) send(8'h55);
      frame(16'h1);
      `CHK(flen, p == 3 ? 11'h1 : 11'(p + 2))
      `CHK(lastb, p == 3 ? 8'h41 : p == 0 ? 8'h0d : 8'h55)
    end
  endtask
  task t_two;
    slow = 1'b1;
    cfg(32'h0a0d, 32'h0, 32'h0);
    send(8'h0d);
    send(8'h41);
    bus(1'b0, 4'hc, 32'h0);
    `CHK(rd, 32'h0000_0002)
    send(8'h0d);
    send(8'h0a);
    frame(16'h1);
    `CHK(flen, 11'h4)
    `CHK(lastb, 8'h0a)
    cfg(32'h0003_0a0d, 32'h0, 32'h0);
    send(8'h41);
    send(8'h0d);
    send(8'h0a);
    frame(16'h1);
    `CHK(flen, 11'h1)
    `CHK(lastb, 8'h41)
  endtask
  task t_limits;
    cfg(32'hff, 32'h3, 32'h0);
    send(8'h01);
    send(8'h02);
    send(8'h03);
    frame(16'h1);
    `CHK(flen, 11'h3)
    // Idle gap of 20 cycles, far above one byte time
    cfg(32'hff, 32'h0, 32'h2);
    send(8'h11);
    send(8'h22);
    frame(16'h1);
    `CHK(flen, 11'h2)
    `CHK(lastb, 8'h22)
    cfg(32'hff, 32'h0, 32'h0);
    for (int k = 0; k < 1024; k++) send(8'(k % 255));
    frame(16'h1);
    `CHK(flen, 11'h400)
    `CHK(lastb, 8'h03)
  endtask
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_nomark();
    t_opts();
    t_two();
    t_limits();
    print_verdict();
  end
endmodule
`default_nettype wire
